// >>> verilog/sssp_pkg.sv
// Purpose: shared constants for the spread spectrum status and probe block
// Assumes: one core clock serves as both IF clocks
// Notes:   offsets are 7-bit write addresses
`default_nettype none
package sssp_pkg;
    localparam int          ADDR_W          = 7;
    localparam int          DATA_W          = 8;
    localparam int          CHIP_CNT_W      = 6;
    localparam int          FIFO_WIDTH      = 2;
    localparam int          FIFO_DEPTH      = 16;
    // register offsets
    localparam logic [6:0]  FREQ_LOAD_ADDR  = 7'h00;
    localparam logic [6:0]  SAMPLE_CTL_ADDR = 7'h01;
    localparam logic [6:0]  SAMPLE_DIV_ADDR = 7'h02;
    localparam logic [6:0]  FCW_BYTE0_ADDR  = 7'h03;
    localparam logic [6:0]  FCW_BYTE3_ADDR  = 7'h06;
    localparam logic [6:0]  ENABLE_ADDR     = 7'h37;
    localparam logic [6:0]  PROBE_SEL_ADDR  = 7'h38;
    // field positions
    localparam int          FREQ_LOAD_BIT   = 0;
    localparam int          EXT_SAMPLE_BIT  = 0;
    localparam int          OSC_EN_BIT      = 0;
    localparam int          RX_EN_BIT       = 2;
    localparam int          SAMPLE_DIV_W    = 6;
    localparam int          PROBE_SEL_W     = 4;
    // reset values
    localparam logic [7:0]  REG_RESET       = 8'h00;
    localparam logic [5:0]  SAMPLE_DIV_RST  = 6'h01;
    // freq word reaches the accumulator on the seventh edge after the trigger
    localparam int          FREQ_LOAD_DELAY = 6;
    // probe selections
    localparam logic [3:0]  PRB_MF_IN       = 4'h0;
    localparam logic [3:0]  PRB_PEAK_PWR    = 4'h1;
    localparam logic [3:0]  PRB_COS         = 4'h2;
    localparam logic [3:0]  PRB_SIN         = 4'h3;
    localparam logic [3:0]  PRB_DC_I        = 4'h4;
    localparam logic [3:0]  PRB_DC_Q        = 4'h5;
    localparam logic [3:0]  PRB_I_SUM       = 4'h6;
    localparam logic [3:0]  PRB_Q_SUM       = 4'h7;
    localparam logic [3:0]  PRB_POWER       = 4'h8;
    localparam logic [3:0]  PRB_VP_I        = 4'h9;
    localparam logic [3:0]  PRB_VP_Q        = 4'ha;
    localparam logic [3:0]  PRB_PEAK_I      = 4'hb;
    localparam logic [3:0]  PRB_PEAK_Q      = 4'hc;
    localparam logic [3:0]  PRB_DOT         = 4'hd;
    localparam logic [3:0]  PRB_CROSS       = 4'he;
    localparam logic [3:0]  PRB_LOOPBACK    = 4'hf;
    // transmit probe selections
    localparam logic [1:0]  TXP_I_SYM       = 2'h0;
    localparam logic [1:0]  TXP_Q_SYM       = 2'h1;
    localparam logic [1:0]  TXP_CODE        = 2'h2;
endpackage
`default_nettype wire

// >>> verilog/sssp_fifo.sv
// Purpose: small flip-flop fifo with valid/ready on both sides
// Assumes: one clock, asynchronous active-low reset
// Notes:   depth must be a power of two
`default_nettype none
module sssp_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    input  wire logic [WIDTH-1:0] wr_data_in,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in,
    output logic      [WIDTH-1:0] rd_data_out
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } sssp_fifo_st_t;

    sssp_fifo_st_t s_q;
    sssp_fifo_st_t s_d;
    logic          push;
    logic          pop;

    ////////////////////////////////////////////////////////////////////////
    assign wr_ready_out = (s_q.cnt != DEPTH[AW:0]);
    assign rd_valid_out = (s_q.cnt != '0);
    assign rd_data_out  = s_q.mem[s_q.rp];
    assign push         = wr_valid_in && wr_ready_out;
    assign pop          = rd_valid_out && rd_ready_in;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = wr_data_in;
            s_d.wp          = s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/sssp_top.sv
// Purpose: status strobes, probes and frequency load of a spread spectrum transceiver
// Assumes: core_clk_in is both IF clocks; datapath values arrive as inputs
// Notes:   registers load on the clock edge while write and select are low
`default_nettype none
module sssp_top
    import sssp_pkg::*;
(
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_n_in,
    // write port
    input  wire logic [ADDR_W-1:0]     addr_in,
    input  wire logic [DATA_W-1:0]     data_in,
    input  wire logic                  wr_n_in,
    input  wire logic                  csel_n_in,
    // pins
    input  wire logic                  freq_load_pin_in,
    input  wire logic                  osc_enable_pin_in,
    input  wire logic                  ext_sample_clock_in,
    input  wire logic                  probe_output_enable_n_in,
    // transmit datapath status
    input  wire logic                  tx_chip_strobe_in,
    input  wire logic [CHIP_CNT_W-1:0] tx_symbol_len_in,
    input  wire logic                  tx_preamble_last_chip_in,
    input  wire logic                  tx_last_symbol_in,
    input  wire logic                  unspread_i_symbol_in,
    input  wire logic                  unspread_q_symbol_in,
    input  wire logic                  spreading_code_probe_in,
    // receive datapath status
    input  wire logic                  rx_qpsk_mode_in,
    input  wire logic                  rx_preamble_det_in,
    input  wire logic                  rx_symbol_det_in,
    input  wire logic                  rx_mid_symbol_in,
    input  wire logic                  rx_burst_end_in,
    input  wire logic                  rx_i_demod_in,
    input  wire logic                  rx_q_demod_in,
    input  wire logic                  rx_hold_in,
    // receive test points
    input  wire logic [2:0]            mf_i_in,
    input  wire logic [2:0]            mf_q_in,
    input  wire logic [7:0]            peak_power_in,
    input  wire logic [7:0]            osc_cos_in,
    input  wire logic [7:0]            osc_sin_in,
    input  wire logic [7:0]            dc_i_in,
    input  wire logic [7:0]            dc_q_in,
    input  wire logic [7:0]            mf_i_sum_in,
    input  wire logic [7:0]            mf_q_sum_in,
    input  wire logic [7:0]            mf_power_in,
    input  wire logic [7:0]            vp_i_sum_in,
    input  wire logic [7:0]            vp_q_sum_in,
    input  wire logic [7:0]            peak_i_in,
    input  wire logic [7:0]            peak_q_in,
    input  wire logic [7:0]            dot_in,
    input  wire logic [7:0]            cross_in,
    input  wire logic [7:0]            loopback_probe_in,
    // outputs
    output logic                       tx_symbol_end_pulse_out,
    output logic                       tx_burst_active_out,
    output logic                       tx_probe_out,
    output logic                       rx_serial_data_out,
    output logic                       rx_serial_valid_out,
    output logic                       rx_i_bit_out,
    output logic                       rx_q_bit_out,
    output logic                       rx_pair_valid_out,
    output logic                       rx_data_ready_n_out,
    output logic                       rx_sample_pulse_out,
    output logic                       rx_symbol_pulse_out,
    output logic                       rx_burst_active_out,
    output logic                       rx_fifo_ready_out,
    output logic [7:0]                 rx_probe_bus_out,
    output logic                       rx_probe_bus_oe_out,
    output logic [31:0]                osc_freq_word_out,
    output logic                       osc_load_done_out,
    output logic                       osc_enabled_out
);

    typedef struct packed {
        logic [7:0]                 freq_load_reg;
        logic [7:0]                 sample_ctl;
        logic [SAMPLE_DIV_W-1:0]    sample_div;
        logic [3:0][7:0]            freq_control_word;
        logic [7:0]                 enables;
        logic [PROBE_SEL_W-1:0]     probe_sel;
        logic [SAMPLE_DIV_W-1:0]    div_cnt;
        logic                       ext_prev;
        logic                       spl;
        logic                       load_or_prev;
        logic [FREQ_LOAD_DELAY-1:0] load_pipe;
        logic [31:0]                osc_word;
        logic                       osc_done;
        logic [CHIP_CNT_W-1:0]      tx_cnt;
        logic                       tx_trk;
        logic                       tx_act;
        logic                       tx_probe;
        logic                       rx_sym;
        logic                       rx_i;
        logic                       rx_q;
        logic                       rx_pair_ok;
        logic                       rx_first;
        logic                       rx_mid_bad;
        logic                       rx_ser;
        logic                       rx_ser_ok;
        logic                       rx_drdy_n;
        logic                       rx_act;
        logic                       rx_end_pend;
        logic [7:0]                 probe;
    } sssp_st_t;

    sssp_st_t                s_q;
    sssp_st_t                s_d;
    logic                    wr_en;
    logic                    tick;
    logic                    osc_en;
    logic                    load_or;
    logic                    fifo_wr_valid;
    logic [FIFO_WIDTH-1:0]   fifo_wr_data;
    logic                    fifo_rd_valid;
    logic                    fifo_rd_ready;
    logic [FIFO_WIDTH-1:0]   fifo_rd_data;

    // probe selection decode
    function automatic logic [7:0] probe_pick(input logic [3:0] sel);
        logic [7:0] v;
        v = 8'h00;
        unique case (sel)
            PRB_MF_IN:    v = {2'h0, mf_q_in, mf_i_in};
            PRB_PEAK_PWR: v = peak_power_in;
            PRB_COS:      v = osc_cos_in;
            PRB_SIN:      v = osc_sin_in;
            PRB_DC_I:     v = dc_i_in;
            PRB_DC_Q:     v = dc_q_in;
            PRB_I_SUM:    v = mf_i_sum_in;
            PRB_Q_SUM:    v = mf_q_sum_in;
            PRB_POWER:    v = mf_power_in;
            PRB_VP_I:     v = vp_i_sum_in;
            PRB_VP_Q:     v = vp_q_sum_in;
            PRB_PEAK_I:   v = peak_i_in;
            PRB_PEAK_Q:   v = peak_q_in;
            PRB_DOT:      v = dot_in;
            PRB_CROSS:    v = cross_in;
            PRB_LOOPBACK: v = loopback_probe_in;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // write port and combined strobes
    assign wr_en   = !wr_n_in && !csel_n_in;
    assign osc_en  = osc_enable_pin_in && s_q.enables[OSC_EN_BIT];
    assign load_or = freq_load_pin_in || s_q.freq_load_reg[FREQ_LOAD_BIT];
    // ext sample input counts only when selected
    assign tick    = s_q.sample_ctl[EXT_SAMPLE_BIT] ?
                     (ext_sample_clock_in && !s_q.ext_prev) :
                     (s_q.div_cnt == s_q.sample_div);

    // fifo lets the controller stall the serial output
    assign fifo_wr_valid = tick && s_q.rx_act &&
                           (rx_symbol_det_in || (rx_qpsk_mode_in && rx_mid_symbol_in));
    assign fifo_wr_data  = rx_symbol_det_in ? {!s_q.rx_first, rx_i_demod_in}
                                            : {!s_q.rx_mid_bad, rx_q_demod_in};
    assign fifo_rd_ready = tick && !rx_hold_in;

    sssp_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk_in  (core_clk_in),
        .rst_n_in     (rst_n_in),
        .wr_valid_in  (fifo_wr_valid),
        .wr_ready_out (rx_fifo_ready_out),
        .wr_data_in   (fifo_wr_data),
        .rd_valid_out (fifo_rd_valid),
        .rd_ready_in  (fifo_rd_ready),
        .rd_data_out  (fifo_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        // registers
        if (wr_en) begin
            unique case (addr_in)
                FREQ_LOAD_ADDR:  s_d.freq_load_reg = data_in;
                SAMPLE_CTL_ADDR: s_d.sample_ctl    = data_in;
                SAMPLE_DIV_ADDR: s_d.sample_div    = data_in[SAMPLE_DIV_W-1:0];
                ENABLE_ADDR:     s_d.enables       = data_in;
                PROBE_SEL_ADDR:  s_d.probe_sel     = data_in[PROBE_SEL_W-1:0];
                default: begin
                    if (addr_in >= FCW_BYTE0_ADDR && addr_in <= FCW_BYTE3_ADDR) begin
                        s_d.freq_control_word[2'(addr_in - FCW_BYTE0_ADDR)] = data_in;
                    end
                end
            endcase
        end
        // receiver disable wipes the probe selection
        if (!s_d.enables[RX_EN_BIT]) begin
            s_d.probe_sel = '0;
        end

        // load: edge of the ored trigger, six stage delay
        s_d.load_or_prev = load_or;
        s_d.load_pipe = {s_q.load_pipe[FREQ_LOAD_DELAY-2:0], load_or && !s_q.load_or_prev};
        s_d.osc_done  = 1'b0;
        if (s_q.load_pipe[FREQ_LOAD_DELAY-1] && osc_en) begin
            s_d.osc_word = s_q.freq_control_word;
            s_d.osc_done = 1'b1;
        end
        // a stopped oscillator forgets its word until the next load
        if (!osc_en) begin
            s_d.osc_word = '0;
        end

        // sample clock
        s_d.ext_prev = ext_sample_clock_in;
        s_d.div_cnt  = (s_q.div_cnt == s_q.sample_div) ? '0 : s_q.div_cnt + 1'b1;
        s_d.spl      = tick;

        // transmit symbol tracking
        s_d.tx_trk = 1'b0;
        if (tx_chip_strobe_in) begin
            if (tx_preamble_last_chip_in) begin
                s_d.tx_act = 1'b1;
                s_d.tx_cnt = '0;
            end else if (s_q.tx_act) begin
                if (s_q.tx_cnt == tx_symbol_len_in - 1'b1) begin
                    s_d.tx_cnt = '0;
                    if (tx_last_symbol_in) begin
                        s_d.tx_act = 1'b0;
                    end
                end else begin
                    s_d.tx_cnt = s_q.tx_cnt + 1'b1;
                end
                if (s_q.tx_cnt == tx_symbol_len_in - 2'd2) begin
                    s_d.tx_trk = 1'b1;
                end
            end
        end
        s_d.tx_probe = 1'b0;
        unique case (addr_in[1:0])
            TXP_I_SYM: s_d.tx_probe = unspread_i_symbol_in;
            TXP_Q_SYM: s_d.tx_probe = unspread_q_symbol_in;
            TXP_CODE:  s_d.tx_probe = spreading_code_probe_in;
            default:   s_d.tx_probe = 1'b0;
        endcase

        // receive side steps only on sample ticks
        if (tick) begin
            s_d.rx_sym = rx_symbol_det_in;
            if (rx_preamble_det_in) begin
                s_d.rx_act      = 1'b1;
                s_d.rx_first    = 1'b1;
                s_d.rx_end_pend = 1'b0;
            end
            if (rx_symbol_det_in && s_q.rx_act) begin
                s_d.rx_i       = rx_i_demod_in;
                s_d.rx_q       = rx_q_demod_in;
                s_d.rx_pair_ok = !s_q.rx_first;
                s_d.rx_mid_bad = s_q.rx_first;
                s_d.rx_first   = 1'b0;
            end
            if (rx_burst_end_in && s_q.rx_act) begin
                s_d.rx_end_pend = 1'b1;
            end
            s_d.rx_drdy_n = 1'b1;
            if (fifo_rd_valid && !rx_hold_in) begin
                s_d.rx_ser    = fifo_rd_data[0];
                s_d.rx_ser_ok = fifo_rd_data[1];
                s_d.rx_drdy_n = 1'b0;
            end else if (s_q.rx_end_pend && !s_q.rx_drdy_n) begin
                s_d.rx_act      = 1'b0;
                s_d.rx_end_pend = 1'b0;
            end
        end

        // probe output stage
        s_d.probe = probe_pick(s_q.probe_sel);

        // rx disable drops the burst
        if (!s_q.enables[RX_EN_BIT]) begin
            s_d.rx_act      = 1'b0;
            s_d.rx_end_pend = 1'b0;
        end
    end

    // everything starts cleared except sample_div (loads 1) and rx_drdy_n (set)
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q            <= '0;
            s_q.sample_div <= SAMPLE_DIV_RST;
            s_q.rx_drdy_n  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign tx_symbol_end_pulse_out = s_q.tx_trk;
    assign tx_burst_active_out     = s_q.tx_act;
    assign tx_probe_out            = s_q.tx_probe;
    assign rx_serial_data_out      = s_q.rx_ser;
    assign rx_serial_valid_out     = s_q.rx_ser_ok;
    assign rx_i_bit_out            = s_q.rx_i;
    assign rx_q_bit_out            = s_q.rx_q;
    assign rx_pair_valid_out       = s_q.rx_pair_ok;
    assign rx_data_ready_n_out     = s_q.rx_drdy_n;
    assign rx_sample_pulse_out     = s_q.spl;
    assign rx_symbol_pulse_out     = s_q.rx_sym;
    assign rx_burst_active_out     = s_q.rx_act;
    assign rx_probe_bus_out        = s_q.probe;
    assign rx_probe_bus_oe_out     = !probe_output_enable_n_in;
    assign osc_freq_word_out       = s_q.osc_word;
    assign osc_load_done_out       = s_q.osc_done;
    assign osc_enabled_out         = osc_en;
endmodule
`default_nettype wire

// >>> verification/sssp_monitor.sv
// Purpose: port-level timing checks for sssp_top
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   attached by bind; watches design outputs plus the probe enable, tx chip strobe and tx preamble inputs
`default_nettype none
module sssp_monitor (
    input wire logic        core_clk_in,
    input wire logic        rst_n_in,
    input wire logic        probe_output_enable_n_in,
    input wire logic        tx_chip_strobe_in,
    input wire logic        tx_preamble_last_chip_in,
    input wire logic        tx_symbol_end_pulse_out,
    input wire logic        tx_burst_active_out,
    input wire logic        rx_data_ready_n_out,
    input wire logic        rx_burst_active_out,
    input wire logic        rx_sample_pulse_out,
    input wire logic        rx_probe_bus_oe_out,
    input wire logic [31:0] osc_freq_word_out,
    input wire logic        osc_load_done_out,
    input wire logic        osc_enabled_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_one(x); x ##1 !x; endsequence
    property p_oe; rx_probe_bus_oe_out == !probe_output_enable_n_in; endproperty
    a_oe: assert property (p_oe) else $error("probe enable wrong");
    property p_txpls; tx_symbol_end_pulse_out |-> s_one(tx_symbol_end_pulse_out); endproperty
    a_txpls: assert property (p_txpls) else $error("pulse too long");
    property p_txact; $rose(tx_burst_active_out) |-> $past(tx_chip_strobe_in && tx_preamble_last_chip_in); endproperty
    a_txact: assert property (p_txact) else $error("tx active rose early");
    property p_word; !osc_enabled_out |=> osc_freq_word_out == 32'h0; endproperty
    a_word: assert property (p_word) else $error("word kept while off");
    property p_drdy; !rx_data_ready_n_out |-> rx_burst_active_out; endproperty
    a_drdy: assert property (p_drdy) else $error("data ready outside burst");
    property p_spl; rx_sample_pulse_out |-> s_one(rx_sample_pulse_out); endproperty
    a_spl: assert property (p_spl) else $error("sample pulse too long");
    property p_done; osc_load_done_out |-> s_one(osc_load_done_out); endproperty
    a_done: assert property (p_done) else $error("load done too long");
    property p_done_en; osc_load_done_out |-> osc_enabled_out; endproperty
    a_done_en: assert property (p_done_en) else $error("load while disabled");
endmodule
bind sssp_top sssp_monitor sssp_monitor_inst (.*);
`default_nettype wire

// >>> verification/sssp_bb_model.sv
// Purpose: baseband controller taking receive serial bits
// Assumes: bits taken at sample pulse while data ready low
// Notes:   only valid bits are shifted in; stall_in drives the hold line
`default_nettype none
module sssp_bb_model (
    input  wire logic   clk_in,
    input  wire logic   stall_in,
    input  wire logic   drdy_n_in,
    input  wire logic   spl_in,
    input  wire logic   bit_in,
    input  wire logic   vld_in,
    output logic        hold_out,
    output logic [15:0] bits_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial bits_out = 16'h0;
    assign hold_out = stall_in;
    // invalid bits dropped
    always @(posedge clk_in) if (spl_in && !drdy_n_in && vld_in) bits_out <= {bits_out[14:0], bit_in};
endmodule
`default_nettype wire

// >>> verification/tb_sssp_top.sv
// Purpose: self-checking bench for sssp_top
// Assumes: 25 MHz clock, inputs driven 1 ns after the rising edge
// Notes:   rx status levels span one sample tick
`default_nettype none
module tb_sssp_top;
    import sssp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_in, rst_n_in, wr_n_in, csel_n_in, freq_load_pin_in, osc_enable_pin_in, ext_sample_clock_in;
    logic probe_output_enable_n_in, tx_chip_strobe_in, tx_preamble_last_chip_in, tx_last_symbol_in, stall;
    logic unspread_i_symbol_in, unspread_q_symbol_in, spreading_code_probe_in, rx_qpsk_mode_in, rx_hold_in;
    logic rx_preamble_det_in, rx_symbol_det_in, rx_mid_symbol_in, rx_burst_end_in, rx_i_demod_in, rx_q_demod_in;
    logic [6:0] addr_in;
    logic [5:0] tx_symbol_len_in;
    logic [2:0] mf_i_in, mf_q_in;
    logic [7:0] data_in, peak_power_in, osc_cos_in, osc_sin_in, dc_i_in, dc_q_in, mf_i_sum_in, mf_q_sum_in;
    logic [7:0] mf_power_in, vp_i_sum_in, vp_q_sum_in, peak_i_in, peak_q_in, dot_in, cross_in, loopback_probe_in;
    logic tx_symbol_end_pulse_out, tx_burst_active_out, tx_probe_out, rx_serial_data_out, rx_serial_valid_out;
    logic rx_i_bit_out, rx_q_bit_out, rx_pair_valid_out, rx_data_ready_n_out, rx_sample_pulse_out;
    logic rx_symbol_pulse_out, rx_burst_active_out, rx_fifo_ready_out, rx_probe_bus_oe_out, osc_load_done_out;
    logic osc_enabled_out;
    logic [7:0] rx_probe_bus_out;
    logic [31:0] osc_freq_word_out;
    logic [127:0] pv;
    logic [15:0] bits;
    int miscompares = 0, cmp_count = 0, pc = 0, dn = 0, sc = 0;
    // selection s sits in byte s
    assign {loopback_probe_in, cross_in, dot_in, peak_q_in, peak_i_in, vp_q_sum_in, vp_i_sum_in, mf_power_in,
            mf_q_sum_in, mf_i_sum_in, dc_q_in, dc_i_in, osc_sin_in, osc_cos_in, peak_power_in} = pv[127:8];
    assign {mf_q_in, mf_i_in} = pv[5:0];
    sssp_top sssp_top_inst (.*);
    sssp_bb_model sssp_bb_model_inst (.clk_in(core_clk_in), .stall_in(stall), .drdy_n_in(rx_data_ready_n_out),
        .spl_in(rx_sample_pulse_out), .bit_in(rx_serial_data_out), .vld_in(rx_serial_valid_out),
        .hold_out(rx_hold_in), .bits_out(bits));
    initial begin
        core_clk_in = 0;
        forever #20 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in) begin
        pc += tx_symbol_end_pulse_out;
        dn += osc_load_done_out;
        sc += rx_sample_pulse_out;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic give_verdict();
        if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            miscompares++;
            give_verdict();
        end
    endtask
    // write port loads on the clock edge: hold strobes over one edge
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        {addr_in, data_in, wr_n_in, csel_n_in} = {a, d, 2'h0};
        cyc(1);
        {wr_n_in, csel_n_in} = 2'h3;
        cyc(1);
    endtask
    task automatic s_probe();
        logic [7:0] m;
        wr(ENABLE_ADDR, 8'h04);
        for (int s = 0; s < 16; s++) begin
            for (int i = 0; i < 16; i++) pv[8*i+:8] = 8'(i * 16 + s);
            m = (s == 0) ? 8'h3f : 8'hff;
            wr(PROBE_SEL_ADDR, 8'(s));
            chk(rx_probe_bus_out & m, pv[8*s+:8] & m);
        end
        probe_output_enable_n_in = 1;
        cyc(1);
        chk(rx_probe_bus_oe_out, 0);
        probe_output_enable_n_in = 0;
        wr(ENABLE_ADDR, 8'h00);
        chk(rx_probe_bus_out & 8'h3f, pv[7:0] & 8'h3f);
        wr(ENABLE_ADDR, 8'h04);
        wr(PROBE_SEL_ADDR, 8'h08);
        chk({rx_probe_bus_oe_out, rx_probe_bus_out}, {1'b1, pv[71:64]});
    endtask
    task automatic s_txprobe();
        for (int a = 0; a < 3; a++) begin
            addr_in = 7'h7c | 7'(a);
            {unspread_i_symbol_in, unspread_q_symbol_in, spreading_code_probe_in} = 3'b100 >> a;
            cyc(1);
            chk(tx_probe_out, 1);
        end
    endtask
    task automatic pin_load();
        int n;
        n = 0;
        freq_load_pin_in = 1;
        while (osc_load_done_out !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        bound(n, 20);
        chk(n, 7);
        chk(osc_freq_word_out, 32'h78563412);
    endtask
    task automatic s_freq();
        osc_enable_pin_in = 1;
        wr(ENABLE_ADDR, 8'h05);
        for (int b = 0; b < 4; b++) wr(FCW_BYTE0_ADDR + 7'(b), 8'h12 + 8'(b) * 8'h22);
        pin_load();
        wr(FREQ_LOAD_ADDR, 8'h01);
        cyc(8);
        chk(dn, 1);
        freq_load_pin_in = 0;
        wr(FREQ_LOAD_ADDR, 8'h00);
        cyc(8);
        wr(FREQ_LOAD_ADDR, 8'h01);
        cyc(8);
        chk(dn, 2);
        wr(FREQ_LOAD_ADDR, 8'h00);
        osc_enable_pin_in = 0;
        cyc(2);
        chk(osc_freq_word_out, 0);
        osc_enable_pin_in = 1;
        cyc(6);
        pin_load();
        freq_load_pin_in = 0;
    endtask
    task automatic tx_chip(input logic pre);
        {tx_chip_strobe_in, tx_preamble_last_chip_in} = {1'b1, pre};
        cyc(1);
        {tx_chip_strobe_in, tx_preamble_last_chip_in} = 2'h0;
        cyc(1);
    endtask
    task automatic s_tx();
        tx_chip(1);
        chk(tx_burst_active_out, 1);
        for (int k = 0; k < 8; k++) begin
            tx_last_symbol_in = (k >= 4);
            if (k == 7) chk(tx_burst_active_out, 1);
            tx_chip(0);
        end
        chk({pc[3:0], tx_burst_active_out}, {4'h2, 1'b0});
    endtask
    task automatic s_ext();
        wr(SAMPLE_CTL_ADDR, 8'h01);
        for (int m = 0; m < 2; m++) begin
            sc = 0;
            repeat (m * 4 + 2) begin
                ext_sample_clock_in = 1;
                cyc(3);
                ext_sample_clock_in = 0;
                cyc(3);
            end
            chk(sc, m ? 18 : 2);
            wr(SAMPLE_CTL_ADDR, 8'h00);
            cyc(1);
        end
    endtask
    // each level spans two clocks: exactly one tick at divider value 1
    task automatic rx_lvl(input logic [3:0] v);
        {rx_preamble_det_in, rx_symbol_det_in, rx_burst_end_in, rx_i_demod_in} = v;
        cyc(2);
    endtask
    task automatic s_rx();
        int n;
        stall = 1;
        rx_lvl(4'h8);
        chk(rx_burst_active_out, 1);
        for (int k = 0; k < 16; k++) rx_lvl({3'b010, 1'(k)});
        rx_lvl(4'h2);
        rx_lvl(4'h0);
        chk({rx_fifo_ready_out, rx_data_ready_n_out}, 2'h1);
        stall = 0;
        n = 0;
        while (rx_burst_active_out === 1'b1 && n < 300) begin
            cyc(1);
            n++;
        end
        bound(n, 300);
        chk(bits, 16'h5555);
        chk(rx_data_ready_n_out, 1);
    endtask
    initial begin
        {rst_n_in, freq_load_pin_in, osc_enable_pin_in, ext_sample_clock_in, probe_output_enable_n_in, stall,
         tx_chip_strobe_in, tx_preamble_last_chip_in, tx_last_symbol_in, unspread_i_symbol_in, unspread_q_symbol_in,
         spreading_code_probe_in, rx_qpsk_mode_in, rx_preamble_det_in, rx_symbol_det_in, rx_mid_symbol_in,
         rx_burst_end_in, rx_i_demod_in, rx_q_demod_in, addr_in, data_in, pv} = '0;
        {wr_n_in, csel_n_in, tx_symbol_len_in} = {2'h3, 6'h04};
        cyc(4);
        rst_n_in = 1;
        chk({rx_data_ready_n_out, osc_freq_word_out[30:0]}, 32'h80000000);
        s_probe();
        s_txprobe();
        s_freq();
        s_tx();
        s_ext();
        s_rx();
        give_verdict();
    end
endmodule
`default_nettype wire
